// *** bench/tb_tbct_timer.sv ***
// Self-checking bench for the timebase capture timer
`timescale 1ns/10ps
`default_nettype none
`include "tbct_map.svh"
module tb_tbct_timer;
    localparam int TICK = 4;
    localparam int TB1_CYC = (`TBCT_TB1_OSC_PERIODS / `TBCT_OSC_DIV) * TICK;
    logic                mclk;
    logic                rst_n;
    tbct_pkg::tbct_req_t busReq;
    logic [7:0]          regRdata;
    logic                capPin;
    logic                haltMode;
    logic                tb1Irq;
    logic                tb2Irq;
    logic                capIrq;
    logic                wake;
    logic                irq;
    int                  err_count;
    int                  total_checks;
    int                  cyc = 0;
    int                  tA;
    logic [7:0]          rd;
    logic [7:0]          relTab [2] = '{8'hff, 8'h00};

    tbct_timer #(.TICK_CYCLES(TICK)) uut (
        .mclk(mclk), .rst_n(rst_n), .busReq(busReq), .regRdata(regRdata),
        .captureInputPin(capPin), .haltMode(haltMode), .timebaseOneIrq(tb1Irq),
        .timebaseTwoIrq(tb2Irq), .captureIrq(capIrq), .haltWakeup(wake), .irq(irq)
    );
    tbct_edge_src src (.mclk(mclk), .capPin(capPin));

    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end
    always @(posedge mclk) cyc <= cyc + 1;

    task automatic stop_test();
        $display("Checks %0d, mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic chkInt(input int got, input int exp, input string what);
        total_checks++;
        if (got != exp) begin
            err_count++;
            $display("Error at %0t: %s got %0d expected %0d", $time, what, got, exp);
        end
    endtask
    task automatic busWrite(input logic [7:0] addr, input logic [7:0] data);
        @(posedge mclk);
        busReq <= '{addr: addr, wdata: data, wr: 1'b1, rd: 1'b0};
        @(posedge mclk);
        busReq.wr <= 1'b0;
        #1;
    endtask
    // Read data stand only in the cycle after the strobe, so they are taken there
    task automatic busRead(input logic [7:0] addr, output logic [7:0] data);
        @(posedge mclk);
        busReq <= '{addr: addr, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge mclk);
        busReq.rd <= 1'b0;
        #1;
        data = regRdata;
    endtask
    task automatic readChk(input logic [7:0] addr, input logic [7:0] exp, input string what);
        logic [7:0] d;
        busRead(addr, d);
        chk8(d, exp, what);
    endtask
    task automatic waitIrq(input int sel, input int limit, output int at);
        logic v;
        at = -1;
        for (int i = 0; i < limit; i++) begin
            @(posedge mclk);
            #1;
            v = (sel == 0) ? tb1Irq : (sel == 1) ? tb2Irq : capIrq;
            if (v === 1'b1) begin
                at = cyc;
                return;
            end
        end
        err_count++;
        $display("Error at %0t: interrupt %0d never rose", $time, sel);
        stop_test();
    endtask
    // Cycles between two flag events; the read between them clears the flag
    task automatic interval(input int sel, input int limit, output int dt);
        int t0;
        int t1;
        waitIrq(sel, limit, t0);
        busRead(sel == 0 ? 8'h0b : 8'h08, rd);
        waitIrq(sel, limit, t1);
        busRead(sel == 0 ? 8'h0b : 8'h08, rd);
        dt = t1 - t0;
    endtask

    initial begin
        busReq = '0;
        rst_n = 1'b0;
        haltMode = 1'b0;
        err_count = 0;
        total_checks = 0;
        repeat (8) @(posedge mclk);
        rst_n <= 1'b1;
        readChk(8'h0b, 8'h40, "status one after reset");
        readChk(8'h0c, 8'h00, "capture after reset");
        readChk(8'h0b, 8'h00, "capture flag cleared");
        readChk(8'h09, 8'h00, "reload after reset");
        readChk(8'h11, 8'h00, "mask after reset");
        readChk(8'h30, 8'h00, "unmapped read");
        $display("Test reset done");
        repeat (TB1_CYC + 100) @(posedge mclk);
        chk8({7'h0, tb1Irq}, 8'h00, "masked timebase one");
        readChk(8'h0b, 8'h08, "timebase one flag");
        readChk(8'h0b, 8'h00, "flag cleared by read");
        busWrite(8'h0b, 8'h98);
        interval(0, TB1_CYC + 100, tA);
        chkInt(tA, TB1_CYC, "timebase one period");
        $display("Test timebase one done");
        // Freeze counter one ten steps after a wrap so the captured count is known
        waitIrq(0, TB1_CYC + 100, tA);
        repeat (40) @(posedge mclk);
        haltMode <= 1'b1;
        busRead(8'h0a, rd);
        repeat (20) @(posedge mclk);
        readChk(8'h0a, rd, "counter two frozen");
        src.makeEdge(3);
        waitIrq(2, 20, tA);
        chk8({7'h0, wake}, 8'h01, "halt wakeup");
        busWrite(8'h0c, 8'hff);
        haltMode <= 1'b0;
        src.makeEdge(3);
        repeat (10) @(posedge mclk);
        readChk(8'h0b, 8'hd8, "capture flag set");
        readChk(8'h0c, 8'h0a, "captured count");
        chk8({7'h0, capIrq}, 8'h00, "capture irq cleared");
        $display("Test capture done");
        readChk(8'h10, 8'h05, "irq status");
        chk8({7'h0, irq}, 8'h00, "all masked");
        busWrite(8'h11, 8'h04);
        chk8({7'h0, irq}, 8'h01, "capture unmasked");
        busWrite(8'h10, 8'h04);
        chk8({7'h0, irq}, 8'h00, "capture status cleared");
        busWrite(8'h11, 8'h01);
        chk8({7'h0, irq}, 8'h01, "timebase one unmasked");
        busWrite(8'h10, 8'h01);
        chk8({7'h0, irq}, 8'h00, "timebase one status cleared");
        $display("Test interrupts done");
        busWrite(8'h0b, 8'hb0);
        interval(0, 2 * TB1_CYC + 100, tA);
        interval(0, 2 * TB1_CYC + 100, tA);
        chkInt(tA, 2 * TB1_CYC, "doubled period");
        $display("Test period double done");
        busWrite(8'h08, 8'h03);
        // Reload limits: one step and the full 256 steps
        foreach (relTab[i]) begin
            busWrite(8'h09, relTab[i]);
            interval(1, 1100, tA);
            interval(1, 1100, tA);
            chkInt(tA, (256 - relTab[i]) * TICK, "counter two period");
        end
        $display("Test counter two done");
        stop_test();
    end
endmodule
`default_nettype wire

// *** bench/tbct_edge_src.sv ***
// Model of the external signal that drives the capture pin
`timescale 1ns/10ps
`default_nettype none
module tbct_edge_src (
    input  wire logic mclk,
    output logic      capPin
);
    initial begin
        capPin = 1'b0;
    end
    // Each level is held several cycles so the two-flop synchroniser cannot miss it
    task automatic makeEdge(input int holdCycles);
        @(posedge mclk);
        capPin <= ~capPin;
        repeat (holdCycles) @(posedge mclk);
    endtask
endmodule
`default_nettype wire

// *** verilog/tbct_edge_sync.sv ***
// Two-stage synchroniser and any-edge detector for the capture pin
`timescale 1ns/10ps
`default_nettype none

module tbct_edge_sync (
    input  wire logic mclk,
    input  wire logic rst_n,
    input  wire logic pinIn,
    output logic      edgePulse
);

    tbct_pkg::tbct_sync_state_t st;
    tbct_pkg::tbct_sync_state_t next_st;

    // Only the second stage feeds the edge compare; the first may be metastable
    always_comb begin
        next_st = st;
        next_st.sync1 = pinIn;
        next_st.sync2 = st.sync1;
        next_st.last = st.sync2;
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign edgePulse = st.sync2 ^ st.last;

    chk_edge_single: assert property (@(posedge mclk) disable iff (!rst_n)
        edgePulse |=> !edgePulse || $changed(st.sync2))
        else $error("edge pulse without a fresh pin change");

endmodule
`default_nettype wire

// *** verilog/tbct_map.svh ***
// Register offsets, field positions, reset values and timing counts of the timebase capture timer
`ifndef TBCT_MAP_SVH
`define TBCT_MAP_SVH

`define TBCT_OFS_CSR2          8'h08
`define TBCT_OFS_RELOAD        8'h09
`define TBCT_OFS_CNT2          8'h0a
`define TBCT_OFS_CSR1          8'h0b
`define TBCT_OFS_CAPTURE       8'h0c
`define TBCT_OFS_IRQ_STAT      8'h10
`define TBCT_OFS_IRQ_MASK      8'h11

`define TBCT_CSR1_CAP_IE_BIT   7
`define TBCT_CSR1_CAP_FLAG_BIT 6
`define TBCT_CSR1_PDOUBLE_BIT  5
`define TBCT_CSR1_TB1_IE_BIT   4
`define TBCT_CSR1_TB1_FLAG_BIT 3
`define TBCT_CSR2_TB2_IE_BIT   1
`define TBCT_CSR2_TB2_FLAG_BIT 0

`define TBCT_IRQ_TB1_BIT       0
`define TBCT_IRQ_TB2_BIT       1
`define TBCT_IRQ_CAP_BIT       2

`define TBCT_RST_RELOAD        8'h00
`define TBCT_RST_CAP_FLAG      1'b1
`define TBCT_CNT2_TOP          8'hff

`define TBCT_CLK_PERIOD_PS     5000
`define TBCT_OSC_PERIOD_PS     125000
`define TBCT_OSC_DIV           32
`define TBCT_TB1_OSC_PERIODS   8000
`define TBCT_TB1_DBL_PERIODS   16000
`define TBCT_TICK_PERIOD_PS    (`TBCT_OSC_DIV * `TBCT_OSC_PERIOD_PS)
`define TBCT_TICK_CYCLES       ((`TBCT_TICK_PERIOD_PS + `TBCT_CLK_PERIOD_PS - 1) / `TBCT_CLK_PERIOD_PS)
`define TBCT_CNT1_TOP          (`TBCT_TB1_OSC_PERIODS / `TBCT_OSC_DIV - 1)

`endif

// *** verilog/tbct_pkg.sv ***
// Types shared by the timebase capture timer
`default_nettype none
package tbct_pkg;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } tbct_req_t;

    typedef struct packed {
        logic [9:0] count;
        logic       tick;
    } tbct_div_state_t;

    typedef struct packed {
        logic sync1;
        logic sync2;
        logic last;
    } tbct_sync_state_t;

    typedef struct packed {
        logic [7:0] cnt1;
        logic       halfTick;
        logic [7:0] cnt2;
        logic [7:0] reload;
        logic [7:0] capVal;
        logic       capFlag;
        logic       capIe;
        logic       periodDouble;
        logic       tb1Flag;
        logic       timebase_one_irq_enable;
        logic       tb2Flag;
        logic       timebase_two_irq_enable;
        logic [2:0] irqStat;
        logic [2:0] irqMask;
        logic [7:0] rdata;
    } tbct_state_t;

endpackage
`default_nettype wire

// *** verilog/tbct_tick_div.sv ***
// Prescaler giving the base oscillator divided by 32 as a one-cycle enable
`timescale 1ns/10ps
`default_nettype none
`include "tbct_map.svh"

module tbct_tick_div #(
    parameter int TICK_CYCLES = `TBCT_TICK_CYCLES
) (
    input  wire logic mclk,
    input  wire logic rst_n,
    output logic      tickEn
);

    tbct_pkg::tbct_div_state_t st;
    tbct_pkg::tbct_div_state_t next_st;

    always_comb begin
        next_st = st;
        next_st.tick = (st.count == 10'(TICK_CYCLES - 1));
        next_st.count = next_st.tick ? 10'h000 : 10'(st.count + 10'h001);
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign tickEn = st.tick;

    chk_tick_spacing: assert property (@(posedge mclk) disable iff (!rst_n)
        tickEn |-> $past(st.count) == 10'(TICK_CYCLES - 1))
        else $error("tick enable out of step with prescaler");

endmodule
`default_nettype wire

// *** verilog/tbct_timer.sv ***
// Timebase capture timer: two timebase counters, input capture and register port
//
// Implementation choices: the plain strobed port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
`include "tbct_map.svh"

module tbct_timer #(
    parameter int TICK_CYCLES = `TBCT_TICK_CYCLES
) (
    input  wire logic                mclk,
    input  wire logic                rst_n,
    input  wire tbct_pkg::tbct_req_t busReq,
    output logic [7:0]               regRdata,
    input  wire logic                captureInputPin,
    input  wire logic                haltMode,
    output logic                     timebaseOneIrq,
    output logic                     timebaseTwoIrq,
    output logic                     captureIrq,
    output logic                     haltWakeup,
    output logic                     irq
);

    localparam logic [7:0] CNT1_TOP = 8'(`TBCT_CNT1_TOP);

    // Capture flag comes out of reset set, so no capture happens until software has read the register
    localparam tbct_pkg::tbct_state_t RESET_STATE = '{
        cnt1:         8'h00,
        halfTick:     1'b0,
        cnt2:         `TBCT_RST_RELOAD,
        reload:       `TBCT_RST_RELOAD,
        capVal:       8'h00,
        capFlag:      `TBCT_RST_CAP_FLAG,
        capIe:        1'b0,
        periodDouble: 1'b0,
        tb1Flag:      1'b0,
        timebase_one_irq_enable:        1'b0,
        tb2Flag:      1'b0,
        timebase_two_irq_enable:        1'b0,
        irqStat:      3'h0,
        irqMask:      3'h0,
        rdata:        8'h00
    };

    tbct_pkg::tbct_state_t st;
    tbct_pkg::tbct_state_t next_st;

    logic       tickEn;
    logic       capEdge;
    logic       run;
    logic       adv1;
    logic       wrap1;
    logic       wrap2;
    logic       capTake;
    logic       rdCsr1;
    logic       rdCsr2;
    logic       rdCap;
    logic       wrCsr1;
    logic       wrCsr2;
    logic       wrReload;
    logic       wrStat;
    logic       wrMask;
    logic [2:0] irqEvent;
    logic [7:0] rdMux;

    tbct_tick_div #(
        .TICK_CYCLES (TICK_CYCLES)
    ) u_tick_div (
        .mclk   (mclk),
        .rst_n  (rst_n),
        .tickEn (tickEn)
    );

    tbct_edge_sync u_edge_sync (
        .mclk      (mclk),
        .rst_n     (rst_n),
        .pinIn     (captureInputPin),
        .edgePulse (capEdge)
    );

    // Register strobes
    always_comb begin
        rdCsr1 = busReq.rd && (busReq.addr == `TBCT_OFS_CSR1);
        rdCsr2 = busReq.rd && (busReq.addr == `TBCT_OFS_CSR2);
        rdCap = busReq.rd && (busReq.addr == `TBCT_OFS_CAPTURE);
        wrCsr1 = busReq.wr && (busReq.addr == `TBCT_OFS_CSR1);
        wrCsr2 = busReq.wr && (busReq.addr == `TBCT_OFS_CSR2);
        wrReload = busReq.wr && (busReq.addr == `TBCT_OFS_RELOAD);
        wrStat = busReq.wr && (busReq.addr == `TBCT_OFS_IRQ_STAT);
        wrMask = busReq.wr && (busReq.addr == `TBCT_OFS_IRQ_MASK);
    end

    // Counter events
    always_comb begin
        run = tickEn && !haltMode;
        adv1 = run && (!st.periodDouble || st.halfTick);
        wrap1 = adv1 && (st.cnt1 == CNT1_TOP);
        wrap2 = run && (st.cnt2 == `TBCT_CNT2_TOP);
        capTake = capEdge && !st.capFlag;
        irqEvent = '0;
        irqEvent[`TBCT_IRQ_TB1_BIT] = wrap1 && st.timebase_one_irq_enable;
        irqEvent[`TBCT_IRQ_TB2_BIT] = wrap2 && st.timebase_two_irq_enable;
        irqEvent[`TBCT_IRQ_CAP_BIT] = capTake && st.capIe;
    end

    // Read data; counter one has no address at all
    always_comb begin
        rdMux = 8'h00;
        case (busReq.addr)
            `TBCT_OFS_CSR2: begin
                rdMux[`TBCT_CSR2_TB2_IE_BIT] = st.timebase_two_irq_enable;
                rdMux[`TBCT_CSR2_TB2_FLAG_BIT] = st.tb2Flag;
            end
            `TBCT_OFS_RELOAD: begin
                rdMux = st.reload;
            end
            `TBCT_OFS_CNT2: begin
                rdMux = st.cnt2;
            end
            `TBCT_OFS_CSR1: begin
                rdMux[`TBCT_CSR1_CAP_IE_BIT] = st.capIe;
                rdMux[`TBCT_CSR1_CAP_FLAG_BIT] = st.capFlag;
                rdMux[`TBCT_CSR1_PDOUBLE_BIT] = st.periodDouble;
                rdMux[`TBCT_CSR1_TB1_IE_BIT] = st.timebase_one_irq_enable;
                rdMux[`TBCT_CSR1_TB1_FLAG_BIT] = st.tb1Flag;
            end
            `TBCT_OFS_CAPTURE: begin
                rdMux = st.capVal;
            end
            `TBCT_OFS_IRQ_STAT: begin
                rdMux[2:0] = st.irqStat;
            end
            `TBCT_OFS_IRQ_MASK: begin
                rdMux[2:0] = st.irqMask;
            end
            default: begin
                rdMux = 8'h00;
            end
        endcase
    end

    // Next state
    always_comb begin
        next_st = st;

        // Half-rate phase doubles the timebase when selected
        if (run) begin
            next_st.halfTick = !st.halfTick;
        end

        if (adv1) begin
            next_st.cnt1 = wrap1 ? 8'h00 : 8'(st.cnt1 + 8'h01);
        end

        // A reload written now is used at the next wrap, not immediately
        if (run) begin
            next_st.cnt2 = wrap2 ? st.reload : 8'(st.cnt2 + 8'h01);
        end

        // Capture register only changes here; writes to its address are ignored
        if (capTake) begin
            next_st.capVal = st.cnt1;
        end

        // Set beats the clearing read in the same cycle
        next_st.tb1Flag = wrap1 || (st.tb1Flag && !rdCsr1);
        next_st.tb2Flag = wrap2 || (st.tb2Flag && !rdCsr2);
        next_st.capFlag = capTake || (st.capFlag && !rdCap);

        if (wrCsr1) begin
            next_st.capIe = busReq.wdata[`TBCT_CSR1_CAP_IE_BIT];
            next_st.periodDouble = busReq.wdata[`TBCT_CSR1_PDOUBLE_BIT];
            next_st.timebase_one_irq_enable = busReq.wdata[`TBCT_CSR1_TB1_IE_BIT];
        end
        if (wrCsr2) begin
            next_st.timebase_two_irq_enable = busReq.wdata[`TBCT_CSR2_TB2_IE_BIT];
        end
        if (wrReload) begin
            next_st.reload = busReq.wdata;
        end
        if (wrMask) begin
            next_st.irqMask = busReq.wdata[2:0];
        end

        // Sticky status, write one to clear, new events win
        next_st.irqStat = irqEvent | (st.irqStat & ~(wrStat ? busReq.wdata[2:0] : 3'h0));

        next_st.rdata = busReq.rd ? rdMux : 8'h00;
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            st <= RESET_STATE;
        end else begin
            st <= next_st;
        end
    end

    // Outputs
    assign regRdata = st.rdata;
    assign timebaseOneIrq = st.tb1Flag && st.timebase_one_irq_enable;
    assign timebaseTwoIrq = st.tb2Flag && st.timebase_two_irq_enable;
    assign captureIrq = st.capFlag && st.capIe;
    // Capture logic runs on the main clock, so an edge can still wake a halted core
    assign haltWakeup = captureIrq;
    assign irq = |(st.irqStat & st.irqMask);

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);

    chk_cnt1_range: assert property (st.cnt1 <= CNT1_TOP)
        else $error("counter one beyond its top value");

    chk_cnt1_wrap: assert property (adv1 && (st.cnt1 == CNT1_TOP) |=> st.cnt1 == 8'h00 && st.tb1Flag)
        else $error("counter one did not wrap to zero with flag");

    chk_cnt1_step: assert property (adv1 && (st.cnt1 != CNT1_TOP) |=> st.cnt1 == 8'($past(st.cnt1) + 8'h01))
        else $error("counter one did not step by one");

    chk_double_rate: assert property (run && st.periodDouble && !st.halfTick |=> $stable(st.cnt1))
        else $error("doubled timebase stepped on the skipped tick");

    chk_halt_freeze: assert property (haltMode |=> $stable(st.cnt1) && $stable(st.cnt2))
        else $error("counter moved during halt");

    chk_tb1_clear: assert property (rdCsr1 && !wrap1 |=> !st.tb1Flag)
        else $error("timebase one flag survived its read");

    chk_flag_set_wins: assert property (rdCsr1 && wrap1 |=> st.tb1Flag)
        else $error("overflow lost against clearing read");

    chk_cap_latch: assert property (capEdge && !st.capFlag |=> st.capFlag && st.capVal == $past(st.cnt1))
        else $error("capture did not latch counter one");

    chk_cap_hold: assert property (st.capFlag && capEdge && !rdCap |=> $stable(st.capVal) && st.capFlag)
        else $error("capture register changed while flag set");

    chk_cap_clear: assert property (rdCap && !capTake |=> !st.capFlag)
        else $error("capture flag survived its read");

    chk_cnt2_reload: assert property (run && st.cnt2 == `TBCT_CNT2_TOP |=> st.cnt2 == $past(st.reload) && st.tb2Flag)
        else $error("counter two did not reload with flag");

    chk_cap_irq: assert property (capTake && st.capIe |=> captureIrq && haltWakeup)
        else $error("enabled capture raised no request");

    chk_rd_data: assert property (rdCap |=> regRdata == $past(st.capVal))
        else $error("capture read returned wrong value");

    chk_tb2_clear: assert property (
        rdCsr2 && !wrap2 |=> !st.tb2Flag)
        else $error("timebase two flag survived its read");

    chk_tb2_set_wins: assert property (
        rdCsr2 && wrap2 |=> st.tb2Flag)
        else $error("counter two overflow lost against clearing read");

    chk_cap_set_wins: assert property (
        rdCap && capTake |=> st.capFlag)
        else $error("capture lost against clearing read");

    chk_cnt2_step: assert property (
        run && (st.cnt2 != `TBCT_CNT2_TOP) |=> st.cnt2 == 8'($past(st.cnt2) + 8'h01))
        else $error("counter two did not step by one");

    chk_cnt2_idle: assert property (
        !run |=> $stable(st.cnt2))
        else $error("counter two moved without a tick");

    chk_cnt1_idle: assert property (
        !adv1 |=> $stable(st.cnt1))
        else $error("counter one moved without a tick");

    chk_half_toggle: assert property (
        run |=> st.halfTick != $past(st.halfTick))
        else $error("half-rate phase did not toggle on a tick");

    chk_tb1_hold: assert property (
        st.tb1Flag && !rdCsr1 |=> st.tb1Flag)
        else $error("timebase one flag dropped without a read");

    chk_cap_masked: assert property (
        capTake && !st.capIe && !wrCsr1 |=> !captureIrq)
        else $error("masked capture raised a request");

    chk_tb1_event: assert property (
        wrap1 && st.timebase_one_irq_enable |=> st.irqStat[`TBCT_IRQ_TB1_BIT])
        else $error("timebase one event missing from status");

    chk_tb2_event: assert property (
        wrap2 && st.timebase_two_irq_enable |=> st.irqStat[`TBCT_IRQ_TB2_BIT])
        else $error("timebase two event missing from status");

    chk_cap_event: assert property (
        capTake && st.capIe |=> st.irqStat[`TBCT_IRQ_CAP_BIT])
        else $error("capture event missing from status");

    chk_stat_clear: assert property (
        wrStat && busReq.wdata[`TBCT_IRQ_TB1_BIT] && !irqEvent[`TBCT_IRQ_TB1_BIT] |=> !st.irqStat[`TBCT_IRQ_TB1_BIT])
        else $error("status bit survived write of one");

    chk_rd_idle: assert property (
        !busReq.rd |=> regRdata == 8'h00)
        else $error("read data outside a read cycle");

    chk_rd_csr1: assert property (
        rdCsr1 |=> regRdata[`TBCT_CSR1_TB1_FLAG_BIT] == $past(st.tb1Flag))
        else $error("status one read lost the flag value");

    chk_reload_write: assert property (
        wrReload |=> st.reload == $past(busReq.wdata))
        else $error("reload write did not land");

    chk_cap_quiet: assert property (
        !capTake |=> $stable(st.capVal))
        else $error("capture register changed without a capture");

    cov_tb1_wrap: cover property (wrap1 && st.timebase_one_irq_enable);
    cov_capture: cover property (capTake ##[1:60] rdCap);
    cov_cap_halt: cover property (capTake && haltMode);
    cov_blocked_edge: cover property (capEdge && st.capFlag);
    cov_cnt2_reload: cover property (wrap2 && st.reload != 8'h00);

endmodule
`default_nettype wire
